// ---- rtl/tec_tx_entry.sv ----
// transmit entry logic for twelve line channels: power gating and clock-input sampling
// assumes channel clocks and data pins are asynchronous to mclk and well below mclk/3
//
// What this block does
// - after reset every channel transmitter is on without any programming.
// - with the power gate high each channel follows its own on/off control bit.
// - with the power gate low all twelve transmitters are forced off.
// - each channel is timed by its own transmit clock input alone.
// - both data rails of a channel are sampled on that channel's transmit clock edge.
// - each channel's pattern generator steps only on that channel's transmit clock edge.
// - in single-rail mode only the positive rail is taken and the negative one is ignored.
`timescale 1ns/100ps

module tec_tx_entry (
    // system
    input wire logic mclk,
    input wire logic srst,
    // power gate pin and per-channel on/off control
    input wire logic transmitPowerGate,
    input wire logic txOnWrite,
    input wire logic [tec_pkg::NUM_CH-1:0] txOnValue,
    // per-channel modes, same clock domain
    input wire logic [tec_pkg::NUM_CH-1:0] singleRail,
    input wire logic [tec_pkg::NUM_CH-1:0] prbsEnable,
    // channel pins from the framer
    input wire logic [tec_pkg::NUM_CH-1:0] channelTxClock,
    input wire logic [tec_pkg::NUM_CH-1:0] txPositiveData,
    input wire logic [tec_pkg::NUM_CH-1:0] txNegativeData,
    // line side drive
    output logic [tec_pkg::NUM_CH-1:0] lineOutPos,
    output logic [tec_pkg::NUM_CH-1:0] lineOutNeg,
    output logic [tec_pkg::NUM_CH-1:0] lineOutEnN,
    output logic [tec_pkg::NUM_CH-1:0] channelActive,
    // sample stream towards the encoder
    output logic sampleValid,
    input wire logic sampleReady,
    output tec_pkg::tec_word_t sampleData,
    // stream status
    output logic captureReady,
    output logic overrun,
    input wire logic overrunClear
);
    import tec_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////
    // helpers

    // one step of the 15-bit pattern register
    function automatic logic [PRBS_W-1:0] prbs_next(input logic [PRBS_W-1:0] cur);
        logic fb;
        fb = cur[PRBS_TAP_A] ^ cur[PRBS_TAP_B];
        return {cur[PRBS_W-2:0], fb};
    endfunction

    // a synchronised level is trusted only once the last two stages agree
    function automatic logic [NUM_CH-1:0] settled(input logic [NUM_CH-1:0] a,
                                                  input logic [NUM_CH-1:0] b);
        return ~(a ^ b);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [NUM_CH-1:0] clkSync1;
    logic [NUM_CH-1:0] clkSync2;
    logic [NUM_CH-1:0] clkSync3;
    logic [NUM_CH-1:0] clkLevel;
    logic [NUM_CH-1:0] posSync1;
    logic [NUM_CH-1:0] posSync2;
    logic [NUM_CH-1:0] posSync3;
    logic [NUM_CH-1:0] negSync1;
    logic [NUM_CH-1:0] negSync2;
    logic [NUM_CH-1:0] negSync3;
    logic gateSync1;
    logic gateSync2;
    logic gateSync3;
    logic gateLevel;
    logic [NUM_CH-1:0] chanOn;
    logic [PRBS_W-1:0] prbsState [NUM_CH];
    logic [NUM_CH-1:0] prbsBit;
    logic [NUM_CH-1:0] enableTrack;

    tec_stream_if #(.WIDTH(WORD_W)) captureLink ();
    tec_stream_if #(.WIDTH(WORD_W)) drainLink ();

    ////////////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, stage one feeds only stage two

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            clkSync1 <= CH_ALL_OFF;
            clkSync2 <= CH_ALL_OFF;
            clkSync3 <= CH_ALL_OFF;
            posSync1 <= CH_ALL_OFF;
            posSync2 <= CH_ALL_OFF;
            posSync3 <= CH_ALL_OFF;
            negSync1 <= CH_ALL_OFF;
            negSync2 <= CH_ALL_OFF;
            negSync3 <= CH_ALL_OFF;
        end
        else
        begin
            clkSync1 <= channelTxClock;
            clkSync2 <= clkSync1;
            clkSync3 <= clkSync2;
            posSync1 <= txPositiveData;
            posSync2 <= posSync1;
            posSync3 <= posSync2;
            negSync1 <= txNegativeData;
            negSync2 <= negSync1;
            negSync3 <= negSync2;
        end
    end

    // gate pin idles high so the synchroniser resets high too
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            gateSync1 <= GATE_RESET_LEVEL;
            gateSync2 <= GATE_RESET_LEVEL;
            gateSync3 <= GATE_RESET_LEVEL;
        end
        else
        begin
            gateSync1 <= transmitPowerGate;
            gateSync2 <= gateSync1;
            gateSync3 <= gateSync2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // settled levels and edge finding, each channel on its own clock pin

    wire [NUM_CH-1:0] clkAgree = settled(clkSync2, clkSync3);
    wire [NUM_CH-1:0] clkRise = clkAgree & clkSync3 & ~clkLevel;
    wire gateAgree = (gateSync2 == gateSync3);

    // a glitch shorter than one mclk never reaches the settled level
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            clkLevel <= CH_ALL_OFF;
            gateLevel <= GATE_RESET_LEVEL;
        end
        else
        begin
            clkLevel <= (clkAgree & clkSync3) | (~clkAgree & clkLevel);
            gateLevel <= gateAgree ? gateSync3 : gateLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // on/off control: per-channel bits gated by the global pin

    // reset leaves every channel on, so the line comes up without software
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            chanOn <= CH_ALL_ON;
        end
        else if (txOnWrite)
        begin
            chanOn <= txOnValue;
        end
    end

    wire [NUM_CH-1:0] gateMask = {NUM_CH{gateLevel}};
    assign enableTrack = chanOn & gateMask;

    ////////////////////////////////////////////////////////////////////////////////////////
    // pattern generators, one per channel, stepped by that channel's edge only

    // a disabled channel does not step, so its sequence resumes where it stopped
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (srst)
            begin
                prbsState[i] <= PRBS_SEED;
            end
            else if (clkRise[i] && enableTrack[i])
            begin
                prbsState[i] <= prbs_next(prbsState[i]);
            end
        end
    end

    // serial pattern bit is the top of each register
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            prbsBit[i] = prbsState[i][PRBS_W-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // rail selection and capture

    // pattern mode replaces the framer data and drives the positive rail only
    wire [NUM_CH-1:0] selPos = (prbsEnable & prbsBit) | (~prbsEnable & posSync3);
    wire [NUM_CH-1:0] selNeg = ~singleRail & ~prbsEnable & negSync3;
    wire [NUM_CH-1:0] capture = clkRise & enableTrack;

    // line drive; outputs of an off channel are parked low and released
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            lineOutPos <= CH_ALL_OFF;
            lineOutNeg <= CH_ALL_OFF;
            lineOutEnN <= CH_ALL_OFF;
            channelActive <= CH_ALL_ON;
        end
        else
        begin
            lineOutPos <= (capture & selPos) | (~capture & enableTrack & lineOutPos);
            lineOutNeg <= (capture & selNeg) | (~capture & enableTrack & lineOutNeg);
            lineOutEnN <= ~enableTrack;
            channelActive <= enableTrack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // capture stream into the fifo

    // a framer cannot be stalled, so a full fifo loses the slice and raises overrun
    tec_word_t captureWord;
    assign captureWord.mask = capture;
    assign captureWord.pos = capture & selPos;
    assign captureWord.neg = capture & selNeg;
    assign captureLink.valid = |capture;
    assign captureLink.data = captureWord;
    wire droppedSlice = captureLink.valid & ~captureLink.ready;

    // sticky overrun: a new loss in the clearing cycle keeps the flag set
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            overrun <= 1'b0;
        end
        else
        begin
            overrun <= droppedSlice | (overrun & ~overrunClear);
        end
    end

    tec_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) sampleFifo (
        .clk(mclk),
        .rst(srst),
        .pushPort(captureLink),
        .popPort(drainLink)
    );

    // fifo outputs are already registered inside it
    assign sampleValid = drainLink.valid;
    assign sampleData = tec_word_t'(drainLink.data);
    assign drainLink.ready = sampleReady;
    assign captureReady = captureLink.ready;
endmodule

// ---- shared/tec_pkg.sv ----
// constants and types shared by the transmit entry block and its sample fifo
// assumes one system clock (mclk, 200 MHz) and twelve independent channels
package tec_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // channel count and pin sampling
    localparam int NUM_CH = 12;
    localparam int SYNC_STAGES = 3;
    localparam logic [NUM_CH-1:0] CH_ALL_ON = 12'hFFF;
    localparam logic [NUM_CH-1:0] CH_ALL_OFF = 12'h000;
    localparam logic GATE_RESET_LEVEL = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////////////
    // pattern generator: x^15 + x^14 + 1
    localparam int PRBS_W = 15;
    localparam int PRBS_TAP_A = 14;
    localparam int PRBS_TAP_B = 13;
    localparam logic [PRBS_W-1:0] PRBS_SEED = 15'h7FFF;

    ////////////////////////////////////////////////////////////////////////////////////////
    // sample stream towards the encoder
    localparam int FIFO_DEPTH = 8;

    // one captured slice: which channels took an edge and their rail values
    typedef struct packed {
        logic [NUM_CH-1:0] mask;
        logic [NUM_CH-1:0] pos;
        logic [NUM_CH-1:0] neg;
    } tec_word_t;

    localparam int WORD_W = $bits(tec_word_t);

endpackage

// ---- shared/tec_stream_if.sv ----
// valid/ready stream carrier used between the entry logic and its fifo
// assumes both ends run on the same clock
`timescale 1ns/100ps

interface tec_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    // producer side
    modport source (output valid, output data, input ready);
    // consumer side
    modport sink (input valid, input data, output ready);
endinterface

// ---- rtl/tec_fifo.sv ----
// synchronous fifo with a registered output stage, valid/ready on both sides
// assumes DEPTH is a power of two so the pointers wrap on their own
`timescale 1ns/100ps

module tec_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // filling side
    tec_stream_if.sink pushPort,
    // draining side
    tec_stream_if.source popPort
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] ZERO_COUNT = '0;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic notFull;
    logic outValid;
    logic [WIDTH-1:0] outData;

    ////////////////////////////////////////////////////////////////////////////////////////
    // handshake terms; the output stage reloads whenever storage holds a word and the stage is empty or being taken
    wire doPush = pushPort.valid & notFull;
    wire doPop = (count != ZERO_COUNT) & (~outValid | popPort.ready);
    assign next_count = count + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};

    assign pushPort.ready = notFull;
    assign popPort.valid = outValid;
    assign popPort.data = outData;

    // storage array carries no reset, only the pointers, count, flags and output word do
    always_ff @(posedge clk)
    begin
        if (doPush)
        begin
            mem[wrPtr] <= pushPort.data;
        end
    end

    // pointers, fill level and a registered full flag so ready is glitch free
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            notFull <= 1'b1;
        end
        else
        begin
            wrPtr <= doPush ? wrPtr + 1'b1 : wrPtr;
            rdPtr <= doPop ? rdPtr + 1'b1 : rdPtr;
            count <= next_count;
            notFull <= (next_count != FULL_COUNT);
        end
    end

    // output register stage holds its word until the consumer takes it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            outValid <= 1'b0;
            outData <= '0;
        end
        else if (doPop)
        begin
            outValid <= 1'b1;
            outData <= mem[rdPtr];
        end
        else if (popPort.ready)
        begin
            outValid <= 1'b0;
        end
    end
endmodule

// ---- tb/tec_tx_entry_monitor.sv ----
// assertions on the transmit entry ports, bound onto the top module
// assumes mclk is the only clock and srst its synchronous reset
`timescale 1ns/100ps

module tec_tx_entry_monitor
    import tec_pkg::*;
(
    // system
    input wire logic mclk,
    input wire logic srst,
    // watched inputs
    input wire logic transmitPowerGate,
    input wire logic txOnWrite,
    input wire logic [NUM_CH-1:0] txOnValue,
    input wire logic [NUM_CH-1:0] prbsEnable,
    input wire logic [NUM_CH-1:0] channelTxClock,
    input wire logic [NUM_CH-1:0] txPositiveData,
    // watched outputs
    input wire logic [NUM_CH-1:0] lineOutPos,
    input wire logic [NUM_CH-1:0] lineOutNeg,
    input wire logic [NUM_CH-1:0] lineOutEnN,
    input wire logic [NUM_CH-1:0] channelActive,
    input wire logic sampleValid,
    input wire logic sampleReady,
    input wire tec_word_t sampleData
);
    logic [3:0] gateHighCnt;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////
    // the gate pin crosses a synchroniser, so only a long-settled high is trusted
    always_ff @(posedge mclk)
    begin
        if (srst || !transmitPowerGate)
            gateHighCnt <= 4'h0;
        else if (gateHighCnt != 4'hF)
            gateHighCnt <= gateHighCnt + 4'h1;
    end

    // power-up state, on-bit writes and the gate override
    a_reset_all_on: assert property ($fell(srst) |-> channelActive == CH_ALL_ON
        && lineOutEnN == CH_ALL_OFF) else $error("transmitters not on after reset");
    a_write_applied: assert property (txOnWrite && gateHighCnt > 4'h7 ##1 !txOnWrite
        |=> channelActive == $past(txOnValue, 2)) else $error("on bits not applied");
    // a write still moves channelActive two edges later, so three quiet cycles are needed
    a_hold_no_write: assert property (!txOnWrite [*3] ##0 gateHighCnt > 4'h8
        |-> $stable(channelActive)) else $error("active changed without a write");
    a_gate_forces_off: assert property (!transmitPowerGate [*7]
        |-> channelActive == CH_ALL_OFF && lineOutEnN == CH_ALL_ON)
        else $error("gate low left a transmitter on");
    a_enable_mirrors: assert property (lineOutEnN == ~channelActive)
        else $error("enable disagrees with active state");
    a_off_rails_parked: assert property (((lineOutPos | lineOutNeg) & lineOutEnN)
        == 0) else $error("released channel drives a rail");
    a_stream_holds: assert property (sampleValid && !sampleReady |=> sampleValid
        && $stable(sampleData)) else $error("word dropped before taken");

    // each channel takes its own positive rail on its own clock edge
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_rail
        a_rail_sampled: assert property ($rose(channelTxClock[i])
            && channelActive[i] && !prbsEnable[i] |-> ##[3:5] lineOutPos[i] == txPositiveData[i])
            else $error("positive rail not taken on clock edge");
    end
endmodule

bind tec_tx_entry tec_tx_entry_monitor mon_u (.mclk, .srst, .transmitPowerGate, .txOnWrite,
    .txOnValue, .prbsEnable, .channelTxClock, .txPositiveData, .lineOutPos, .lineOutNeg,
    .lineOutEnN, .channelActive, .sampleValid, .sampleReady, .sampleData);

// ---- tb/tec_framer_model.sv ----
// framer model: channel clocks and both data rails towards the block
// assumes the bench opens a frame by setting frameMask and closes it by clearing it
`timescale 1ns/100ps

module tec_framer_model (
    // frame control
    input wire logic [tec_pkg::NUM_CH-1:0] frameMask,
    // pins towards the block
    output logic [tec_pkg::NUM_CH-1:0] channelTxClock,
    output logic [tec_pkg::NUM_CH-1:0] txPositiveData,
    output logic [tec_pkg::NUM_CH-1:0] txNegativeData
);
    import tec_pkg::*;
    logic phase;
    logic [31:0] state;

    ////////////////////////////////////////
    // 64 ns stand-in for the line rate; clocks stand low between frames,
    // data moves every falling half so a stale level is never worth trusting
    initial
    begin
        phase = 1'b0;
        state = 32'h00006A5D;
        channelTxClock = CH_ALL_OFF;
        txPositiveData = CH_ALL_OFF;
        txNegativeData = CH_ALL_OFF;
        forever
        begin
            #32;
            phase = !phase;
            channelTxClock = phase ? frameMask : CH_ALL_OFF;
            if (!phase)
            begin
                state = state ^ (state << 13);
                state = state ^ (state >> 17);
                state = state ^ (state << 5);
                txPositiveData = state[11:0];
                txNegativeData = state[27:16];
            end
        end
    end
endmodule

// ---- tb/tec_tx_entry_tb_top.sv ----
// self-checking bench for the transmit entry block with a framer model on its pins
// assumes mclk at 200 MHz and framer clocks of 64 ns running only inside frames
`timescale 1ns/100ps

module tec_tx_entry_tb_top;
    import tec_pkg::*;
    logic mclk, srst, transmitPowerGate, txOnWrite, sampleReady, overrunClear;
    logic sampleValid, captureReady, overrun;
    logic [NUM_CH-1:0] txOnValue, singleRail, prbsEnable, frameMask, v, m;
    logic [NUM_CH-1:0] channelTxClock, txPositiveData, txNegativeData;
    logic [NUM_CH-1:0] lineOutPos, lineOutNeg, lineOutEnN, channelActive;
    tec_word_t sampleData;
    logic [31:0] seed = 32'h000064DB;
    logic [PRBS_W-1:0] prbsReg;
    int failures = 0;
    int checks = 0;
    int words;

    tec_tx_entry dut_u (.mclk, .srst, .transmitPowerGate, .txOnWrite, .txOnValue, .singleRail,
        .prbsEnable, .channelTxClock, .txPositiveData, .txNegativeData, .lineOutPos,
        .lineOutNeg, .lineOutEnN, .channelActive, .sampleValid, .sampleReady, .sampleData,
        .captureReady, .overrun, .overrunClear);
    tec_framer_model frm_u (.frameMask, .channelTxClock, .txPositiveData, .txNegativeData);

    ////////////////////////////////////////
    // 5 ns system clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // pattern bit is the msb before the shift
    function automatic logic prbs_bit();
        logic b;
        b = prbsReg[PRBS_W-1];
        prbsReg = {prbsReg[PRBS_W-2:0], prbsReg[PRBS_TAP_A] ^ prbsReg[PRBS_TAP_B]};
        return b;
    endfunction

    // inputs always move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic set_on(input logic [NUM_CH-1:0] val);
        txOnWrite = 1'b1;
        txOnValue = val;
        cyc(1);
        txOnWrite = 1'b0;
        cyc(2);
        check("active", channelActive, val);
        check("enable", lineOutEnN, val ^ CH_ALL_ON);
    endtask

    // frame of n periods, then time for the syncs to drain
    task automatic frame(input logic [NUM_CH-1:0] fm, input int n);
        frameMask = fm;
        #(64 * n);
        frameMask = CH_ALL_OFF;
        #70;
        cyc(8);
    endtask

    // hand over every queued word; bounded so a stuck valid cannot hang the run
    task automatic drain(input logic [NUM_CH-1:0] ok, output int n);
        int idle;
        tec_word_t w;
        n = 0;
        idle = 0;
        sampleReady = 1'b1;
        for (int k = 0; k < 40 && idle < 4; k++)
        begin
            w = sampleData;
            if (sampleValid === 1'b1)
            begin
                n++;
                idle = 0;
                check("mask", w.mask & ~ok, 0);
                check("neg", w.neg & ~(w.mask & ~singleRail & ~prbsEnable), 0);
                check("pos", w.pos & ~w.mask, 0);
                if (prbsEnable[0] && w.mask[0])
                    check("prbs", w.pos[0], prbs_bit());
            end
            else
                idle++;
            cyc(1);
        end
        sampleReady = 1'b0;
        // a queue that never runs dry means a stuck valid: count it and stop
        if (idle < 4)
        begin
            failures++;
            end_of_test();
        end
    endtask

    initial
    begin
        srst = 1'b1;
        transmitPowerGate = 1'b1;
        txOnWrite = 1'b0;
        txOnValue = CH_ALL_OFF;
        singleRail = CH_ALL_OFF;
        prbsEnable = CH_ALL_OFF;
        frameMask = CH_ALL_OFF;
        sampleReady = 1'b0;
        overrunClear = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        srst = 1'b0;
        cyc(1);
        check("power up", channelActive, CH_ALL_ON);
        $display("done reset");
        set_on(CH_ALL_OFF);
        set_on(CH_ALL_ON);
        for (int i = 0; i < 4; i++)
            set_on(NUM_CH'(rnd()));
        v = txOnValue;
        transmitPowerGate = 1'b0;
        cyc(8);
        check("gate low", channelActive, CH_ALL_OFF);
        transmitPowerGate = 1'b1;
        cyc(8);
        check("gate high", channelActive, v);
        $display("done control");
        // mixed rails on random channels, some switched off
        for (int i = 0; i < 3; i++)
        begin
            v = NUM_CH'(rnd()) | 12'h001;
            set_on(v);
            singleRail = NUM_CH'(rnd());
            m = NUM_CH'(rnd()) | 12'h001;
            frame(m, 6);
            drain(m & v, words);
            check("word count", words > 4, 1'b1);
        end
        $display("done traffic");
        // pattern generator from a clean reset, one channel only
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        cyc(4);
        prbsReg = PRBS_SEED;
        prbsEnable = 12'h001;
        frame(12'h001, 8);
        drain(12'h001, words);
        check("pattern words", words, 8);
        prbsEnable = CH_ALL_OFF;
        $display("done pattern");
        // overfill with the consumer stalled, then drain to empty
        frame(CH_ALL_ON, 12);
        check("full", captureReady, 1'b0);
        check("lost", overrun, 1'b1);
        overrunClear = 1'b1;
        cyc(1);
        overrunClear = 1'b0;
        cyc(1);
        check("cleared", overrun, 1'b0);
        drain(CH_ALL_ON, words);
        check("depth", words, FIFO_DEPTH + 1);
        check("not full", captureReady, 1'b1);
        $display("done buffer");
        end_of_test();
    end
endmodule
